// File: src/tcbd_decoder.sv
// transport command block decoder: routes, executes and completes blocks
// assumes one block offered at a time; completion sink never stalls
//
// How it works
// - destination bit clear goes to queued agent, set goes to immediate
// - codes 1,2,3 are transfer, requested read, direct-status response
// - codes 8,9,A,B are acquire, release, abdicate, basic status
// - codes 70 to 73 open and close channels; 74 to 7F reserved
// - parameter area read per function code and enabled control set
// - transfer takes buffer fields and direction from the block
// - target tracks delivered bytes; buffer may be shorter than announced
// - matching direct-status response cancels request and discards its data
// - acquire completes at once, or with wait set only on success or a refused selector
// - selector 0 is class resource; 1 to F reserved; only the first NRES-1 set selectors from 10 are mapped
// - contention on each resource arbitrated, one owner at a time
// - abdicate accept one gives the resource up, zero refuses
// - every block carries a logical channel number used for matching
// - completion source bit zero for queued, one for immediate agent
// - read-request and direct-status announcements are answered by blocks
//
// Design decisions made here: the register addresses and the address-and-strobe port.
`include "tcbd_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module tcbd_decoder
  import tcbd_pkg::*;
#(
  parameter int DEPTH = 4,
  parameter int NRES = 4
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic i_cmd_valid,
  input wire tcbd_cmd_t i_cmd,
  output logic o_cmd_ready,
  input wire logic i_ann_valid,
  input wire tcbd_ann_t i_ann,
  output logic o_ann_ready,
  output logic o_xfer_valid,
  output tcbd_xfer_t o_xfer,
  input wire logic i_xfer_done,
  output logic o_cpl_valid,
  output tcbd_cpl_t o_cpl,
  output logic o_fwd_valid,
  output tcbd_cmd_t o_fwd,
  output logic o_discard_valid,
  output tcbd_ann_t o_discard,
  input wire logic [3:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata
);
  localparam int IW = $clog2(DEPTH);

  // the table width and the status field both limit the sizes
  if (DEPTH < 2 || DEPTH > 255 || NRES < 1 || NRES > 8) begin : g_chk
    $error("tcbd_decoder: DEPTH must be 2..255 and NRES 1..8");
  end

  typedef struct packed {
    tcbd_fsm_t fsm;
    tcbd_cmd_t cmd;
    logic cmd_ready;
    logic ann_ready;
    logic xfer_valid;
    tcbd_xfer_t xfer;
    logic cpl_valid;
    tcbd_cpl_t cpl;
    logic fwd_valid;
    logic discard_valid;
    tcbd_ann_t discard;
    logic [1:0] ctrl;
    logic [15:0] n_done;
    logic [15:0] n_err;
    logic [31:0] rdata;
    tcbd_pend_t [DEPTH-1:0] pend;
  } tcbd_st_t;

  tcbd_st_t st;
  tcbd_st_t next_st;
  tcbd_rop_t res_op;
  logic res_ok;
  logic res_bad;
  logic [NRES-1:0] res_busy;
  logic [IW:0] m_rr;
  logic [IW:0] m_any;
  logic [15:0] rr_len;

  // tag lookup by channel and sequence; rr_only skips direct status
  function automatic logic [IW:0] find_pend(input tcbd_pend_t [DEPTH-1:0] p,
                                            input logic [15:0] lcn,
                                            input logic [15:0] seq,
                                            input logic rr_only);
    logic [IW:0] r;
    r = '0;
    for (int i = DEPTH - 1; i >= 0; i--) begin
      if (p[i].v && p[i].lcn == lcn && p[i].seq == seq &&
          (p[i].rr || !rr_only)) begin
        r = {1'b1, IW'(i)};
      end
    end
    return r;
  endfunction

  // first free slot of the table, with a found flag on top
  function automatic logic [IW:0] find_free(input tcbd_pend_t [DEPTH-1:0] p);
    logic [IW:0] r;
    r = '0;
    for (int i = DEPTH - 1; i >= 0; i--) begin
      if (!p[i].v) begin
        r = {1'b1, IW'(i)};
      end
    end
    return r;
  endfunction

  function automatic logic [7:0] count_pend(input tcbd_pend_t [DEPTH-1:0] p);
    logic [7:0] n;
    n = 8'h00;
    for (int i = 0; i < DEPTH; i++) begin
      n = n + {7'h00, p[i].v};
    end
    return n;
  endfunction

  // reserved codes; control-set codes count as reserved when no set is on
  function automatic logic fn_reserved(input logic [7:0] fn,
                                       input logic cset_on);
    logic r;
    r = 1'b0;
    if (fn == 8'h00 || (fn > `TCBD_FN_DSRSP && fn < `TCBD_FN_ACQ)) begin
      r = 1'b1;
    end else if (fn > `TCBD_FN_BDS && fn < `TCBD_FN_CSET_LO) begin
      r = 1'b1;
    end else if (fn >= `TCBD_FN_CSET_LO && fn <= `TCBD_FN_CSET_HI) begin
      r = !cset_on;
    end else if (fn > `TCBD_FN_CHAN_HI) begin
      r = 1'b1;
    end
    return r;
  endfunction

  assign m_rr = find_pend(st.pend, st.cmd.lcn, st.cmd.seq, 1'b1);
  assign m_any = find_pend(st.pend, st.cmd.lcn, st.cmd.seq, 1'b0);
  // deliver no more than is still owed on the announcement
  assign rr_len = (st.cmd.size < st.pend[m_rr[IW-1:0]].rem) ?
                  st.cmd.size : st.pend[m_rr[IW-1:0]].rem;

  // resource operation is a pure function of registered state
  always_comb begin
    res_op = ROP_NONE;
    if (st.fsm == ST_EXEC && !st.cmd.imm | st.cmd.imm) begin
      case (st.cmd.fn)
        `TCBD_FN_ACQ: res_op = ROP_ACQ;
        `TCBD_FN_REL: res_op = ROP_REL;
        `TCBD_FN_ABD: res_op = st.cmd.accept ? ROP_ABD : ROP_NONE;
        default: res_op = ROP_NONE;
      endcase
    end
    if (st.fsm != ST_EXEC) begin
      res_op = ROP_NONE;
    end
    if (st.fsm == ST_WAIT && !st.xfer_valid) begin
      res_op = ROP_ACQ; // retry a waiting acquire every cycle
    end
  end

  tcbd_res_arb #(
    .NRES(NRES)
  ) u_res (
    .i_clk_sys(i_clk_sys),
    .i_rst_b(i_rst_b),
    .i_op(res_op),
    .i_sel(st.cmd.sel),
    .i_lcn(st.cmd.lcn),
    .o_ok(res_ok),
    .o_bad(res_bad),
    .o_busy(res_busy)
  );

  // decode, execution, table upkeep and register access
  always_comb begin
    logic [IW:0] slot;
    next_st = st;
    slot = '0;
    next_st.cpl_valid = 1'b0;
    next_st.fwd_valid = 1'b0;
    next_st.discard_valid = 1'b0;
    next_st.rdata = 32'h0000_0000;
    case (st.fsm)
      ST_IDLE: begin
        if (i_cmd_valid && st.cmd_ready) begin
          next_st.cmd = i_cmd;
          next_st.fsm = ST_EXEC;
        end
      end
      ST_EXEC: begin
        next_st.fsm = ST_CPL;
        next_st.cpl_valid = 1'b1;
        next_st.cpl.lcn = st.cmd.lcn;
        next_st.cpl.src = st.cmd.imm;
        next_st.cpl.fn = st.cmd.fn;
        next_st.cpl.code = `TCBD_CPL_OK;
        next_st.xfer.lcn = st.cmd.lcn;
        next_st.xfer.agent = st.cmd.imm;
        next_st.xfer.dir = st.cmd.dir;
        next_st.xfer.ptp = st.cmd.ptp;
        next_st.xfer.page = st.cmd.page;
        next_st.xfer.size = st.cmd.size;
        next_st.xfer.desc = st.cmd.desc;
        if (fn_reserved(st.cmd.fn, st.ctrl[`TCBD_CTRL_CSET])) begin
          next_st.cpl.code = `TCBD_CPL_ERR_RSV;
        end else if (st.cmd.fn == `TCBD_FN_XFER) begin
          next_st.cpl_valid = 1'b0;
          next_st.xfer_valid = 1'b1;
          next_st.fsm = ST_WAIT;
        end else if (st.cmd.fn == `TCBD_FN_RREAD) begin
          if (m_rr[IW]) begin
            next_st.cpl_valid = 1'b0;
            next_st.xfer_valid = 1'b1;
            next_st.xfer.size = rr_len;
            next_st.fsm = ST_WAIT;
            next_st.pend[m_rr[IW-1:0]].rem =
              st.pend[m_rr[IW-1:0]].rem - rr_len;
            if (st.pend[m_rr[IW-1:0]].rem == rr_len) begin
              next_st.pend[m_rr[IW-1:0]].v = 1'b0;
            end
          end else begin
            next_st.cpl.code = `TCBD_CPL_ERR_NOMATCH;
          end
        end else if (st.cmd.fn == `TCBD_FN_DSRSP) begin
          if (m_any[IW]) begin
            next_st.pend[m_any[IW-1:0]].v = 1'b0;
            next_st.discard_valid = st.pend[m_any[IW-1:0]].rr;
            next_st.discard.lcn = st.pend[m_any[IW-1:0]].lcn;
            next_st.discard.seq = st.pend[m_any[IW-1:0]].seq;
            next_st.discard.len = st.pend[m_any[IW-1:0]].rem;
            next_st.discard.rr = st.pend[m_any[IW-1:0]].rr;
          end else begin
            next_st.cpl.code = `TCBD_CPL_ERR_NOMATCH;
          end
        end else if (st.cmd.fn == `TCBD_FN_ACQ) begin
          if (res_bad) begin
            next_st.cpl.code = `TCBD_CPL_ERR_RES;
          end else if (!res_ok && st.cmd.wait_b) begin
            next_st.cpl_valid = 1'b0;
            next_st.fsm = ST_WAIT;
          end else if (!res_ok) begin
            next_st.cpl.code = `TCBD_CPL_DENIED;
          end
        end else if (st.cmd.fn == `TCBD_FN_REL ||
                     (st.cmd.fn == `TCBD_FN_ABD && st.cmd.accept)) begin
          if (res_bad) begin
            next_st.cpl.code = `TCBD_CPL_ERR_RES;
          end
        end else if (st.cmd.fn != `TCBD_FN_ABD) begin
          next_st.fwd_valid = 1'b1;
        end
      end
      ST_WAIT: begin
        if (st.xfer_valid) begin
          if (i_xfer_done) begin
            next_st.xfer_valid = 1'b0;
            next_st.cpl_valid = 1'b1;
            next_st.fsm = ST_CPL;
          end
        end else if (res_ok || res_bad) begin
          next_st.cpl_valid = 1'b1;
          next_st.cpl.code = res_ok ? `TCBD_CPL_OK : `TCBD_CPL_ERR_RES;
          next_st.fsm = ST_CPL;
        end
      end
      ST_CPL: begin
        next_st.fsm = ST_IDLE;
      end
      default: begin
        next_st.fsm = ST_IDLE;
      end
    endcase

    // announcements fill a slot that survives this cycle's clears
    if (i_ann_valid && st.ann_ready) begin
      slot = find_free(next_st.pend);
      next_st.pend[slot[IW-1:0]].v = slot[IW];
      next_st.pend[slot[IW-1:0]].rr = i_ann.rr;
      next_st.pend[slot[IW-1:0]].lcn = i_ann.lcn;
      next_st.pend[slot[IW-1:0]].seq = i_ann.seq;
      next_st.pend[slot[IW-1:0]].rem = i_ann.len;
    end
    next_st.ann_ready = find_free(next_st.pend) >> IW != '0;

    // register writes; a same-cycle completion is counted after a counter clear
    if (i_wr) begin
      case (i_addr)
        `TCBD_REG_CTRL: next_st.ctrl = i_wdata[1:0];
        `TCBD_REG_CNT: begin
          next_st.n_done = 16'h0000;
          next_st.n_err = 16'h0000;
        end
        default: begin
        end
      endcase
    end
    if (next_st.cpl_valid) begin
      if (next_st.cpl.code == `TCBD_CPL_OK) begin
        next_st.n_done = next_st.n_done + 16'h0001;
      end else begin
        next_st.n_err = next_st.n_err + 16'h0001;
      end
    end
    if (i_rd) begin
      case (i_addr)
        `TCBD_REG_CTRL: next_st.rdata = {30'h0, st.ctrl};
        `TCBD_REG_STAT: begin
          next_st.rdata[1:0] = st.fsm;
          next_st.rdata[`TCBD_STAT_CNT_LSB +: 8] = count_pend(st.pend);
          next_st.rdata[`TCBD_STAT_BUSY_LSB +: NRES] = res_busy;
        end
        `TCBD_REG_CNT: next_st.rdata = {st.n_err, st.n_done};
        default: next_st.rdata = 32'h0000_0000;
      endcase
    end

    // a disabled decoder finishes its block but takes no new one
    next_st.cmd_ready = next_st.fsm == ST_IDLE && next_st.ctrl[`TCBD_CTRL_EN];
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st <= '0;
      st.ctrl <= `TCBD_CTRL_RST;
    end else begin
      st <= next_st;
    end
  end

  // outputs are state fields, so all of them come from flip-flops
  assign o_cmd_ready = st.cmd_ready;
  assign o_ann_ready = st.ann_ready;
  assign o_xfer_valid = st.xfer_valid;
  assign o_xfer = st.xfer;
  assign o_cpl_valid = st.cpl_valid;
  assign o_cpl = st.cpl;
  assign o_fwd_valid = st.fwd_valid;
  assign o_fwd = st.cmd;
  assign o_discard_valid = st.discard_valid;
  assign o_discard = st.discard;
  assign o_rdata = st.rdata;

  default clocking d_cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_b);

  a_cpl_source: assert property (o_cpl_valid |->
    o_cpl.src == st.cmd.imm && o_cpl.lcn == st.cmd.lcn)
    else $error("completion source or channel wrong");
  a_xfer_route: assert property ((st.fsm == ST_EXEC &&
    st.cmd.fn == `TCBD_FN_XFER) |=> o_xfer_valid && !o_cpl_valid &&
    o_xfer.dir == st.cmd.dir && o_xfer.agent == st.cmd.imm &&
    o_xfer.size == st.cmd.size)
    else $error("transfer not issued from block fields");
  a_rsv_error: assert property ((st.fsm == ST_EXEC &&
    fn_reserved(st.cmd.fn, st.ctrl[`TCBD_CTRL_CSET])) |=> o_cpl_valid &&
    o_cpl.code == `TCBD_CPL_ERR_RSV && !o_xfer_valid && !o_fwd_valid)
    else $error("reserved code not completed with error");
  a_rr_bound: assert property ((st.fsm == ST_EXEC &&
    st.cmd.fn == `TCBD_FN_RREAD && m_rr[IW]) |=> o_xfer_valid &&
    o_xfer.size <= $past(st.cmd.size))
    else $error("requested read longer than its buffer");
  a_nomatch_err: assert property ((st.fsm == ST_EXEC &&
    !m_any[IW] &&
    (st.cmd.fn == `TCBD_FN_RREAD || st.cmd.fn == `TCBD_FN_DSRSP)) |=>
    o_cpl_valid && o_cpl.code == `TCBD_CPL_ERR_NOMATCH)
    else $error("unmatched tag not flagged");
  a_ds_discard: assert property ((st.fsm == ST_EXEC && m_rr[IW] &&
    st.cmd.fn == `TCBD_FN_DSRSP) |=> o_discard_valid &&
    o_discard.seq == $past(st.cmd.seq) ##1 !o_discard_valid)
    else $error("matched read request not discarded");
  a_acq_nowait: assert property ((st.fsm == ST_EXEC &&
    !st.cmd.wait_b && st.cmd.fn == `TCBD_FN_ACQ) |=> o_cpl_valid ##1
    st.fsm == ST_IDLE)
    else $error("acquire without wait not completed at once");
  a_acq_hold: assert property ((st.fsm == ST_WAIT &&
    !st.xfer_valid && !res_ok && !res_bad) |=> !o_cpl_valid &&
    st.fsm == ST_WAIT)
    else $error("waiting acquire completed before grant");
  a_fwd_class: assert property (o_fwd_valid |->
    !fn_reserved(o_fwd.fn, st.ctrl[`TCBD_CTRL_CSET]) &&
    o_fwd.fn >= `TCBD_FN_BDS)
    else $error("forwarded a code handled here");

  c_xfer: cover property (o_xfer_valid && i_xfer_done ##1 o_cpl_valid);
  c_rr_partial: cover property (st.fsm == ST_EXEC && m_rr[IW] &&
    st.cmd.fn == `TCBD_FN_RREAD && rr_len < st.pend[m_rr[IW-1:0]].rem);
  c_acq_wait: cover property (st.fsm == ST_WAIT && !st.xfer_valid ##1
    st.fsm == ST_WAIT ##1 o_cpl_valid);
  c_discard: cover property (o_discard_valid);

endmodule

`default_nettype wire

// File: inc/tcbd_defs.svh
// constants of the transport command block decoder
// assumes it is included by bare name from the package and the design files
`ifndef TCBD_DEFS_SVH
`define TCBD_DEFS_SVH

// function codes, full-duplex category
`define TCBD_FN_XFER 8'h01
`define TCBD_FN_RREAD 8'h02
`define TCBD_FN_DSRSP 8'h03
// function codes, device-control category
`define TCBD_FN_ACQ 8'h08
`define TCBD_FN_REL 8'h09
`define TCBD_FN_ABD 8'h0A
`define TCBD_FN_BDS 8'h0B
`define TCBD_FN_CSET_LO 8'h10
`define TCBD_FN_CSET_HI 8'h6F
// function codes, channel-control category
`define TCBD_FN_CHAN_LO 8'h70
`define TCBD_FN_CHAN_HI 8'h73
// resource selectors
`define TCBD_RES_CLASS 8'h00
`define TCBD_RES_CSET_LO 8'h10
`define TCBD_RES_CSET_HI 8'h7F
// completion codes
`define TCBD_CPL_OK 4'h0
`define TCBD_CPL_DENIED 4'h1
`define TCBD_CPL_ERR_RSV 4'h2
`define TCBD_CPL_ERR_NOMATCH 4'h3
`define TCBD_CPL_ERR_RES 4'h4
// register offsets and fields
`define TCBD_REG_CTRL 4'h0
`define TCBD_REG_STAT 4'h4
`define TCBD_REG_CNT 4'h8
`define TCBD_CTRL_EN 0
`define TCBD_CTRL_CSET 1
`define TCBD_CTRL_RST 2'h1
`define TCBD_STAT_CNT_LSB 8
`define TCBD_STAT_BUSY_LSB 16

`endif

// File: inc/tcbd_pkg.sv
// types shared by the command block decoder and its resource arbiter
// assumes tcbd_defs.svh sits on the include path
`include "tcbd_defs.svh"

package tcbd_pkg;

  // one command block as delivered by the fetch engine
  typedef struct packed {
    logic [15:0] lcn;
    logic imm;
    logic [7:0] fn;
    logic dir;
    logic ptp;
    logic [3:0] page;
    logic [15:0] size;
    logic [31:0] desc;
    logic [15:0] seq;
    logic wait_b;
    logic accept;
    logic [7:0] sel;
  } tcbd_cmd_t;

  // announced status (read request or direct), also used for discards
  typedef struct packed {
    logic [15:0] lcn;
    logic [15:0] seq;
    logic [15:0] len;
    logic rr;
  } tcbd_ann_t;

  // one outstanding announcement
  typedef struct packed {
    logic v;
    logic rr;
    logic [15:0] lcn;
    logic [15:0] seq;
    logic [15:0] rem;
  } tcbd_pend_t;

  typedef struct packed {
    logic [15:0] lcn;
    logic src;
    logic [7:0] fn;
    logic [3:0] code;
  } tcbd_cpl_t;

  typedef struct packed {
    logic [15:0] lcn;
    logic agent;
    logic dir;
    logic ptp;
    logic [3:0] page;
    logic [15:0] size;
    logic [31:0] desc;
  } tcbd_xfer_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_WAIT = 2'b11,
    ST_CPL = 2'b10
  } tcbd_fsm_t;

  typedef enum logic [1:0] {
    ROP_NONE = 2'b00,
    ROP_ACQ = 2'b01,
    ROP_REL = 2'b10,
    ROP_ABD = 2'b11
  } tcbd_rop_t;

endpackage

// File: src/tcbd_res_arb.sv
// device resource arbiter: one owner channel per resource slot
// assumes one operation per cycle; answers in the same cycle
`include "tcbd_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module tcbd_res_arb
  import tcbd_pkg::*;
#(
  parameter int NRES = 4
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire tcbd_rop_t i_op,
  input wire logic [7:0] i_sel,
  input wire logic [15:0] i_lcn,
  output logic o_ok,
  output logic o_bad,
  output logic [NRES-1:0] o_busy
);
  localparam int SW = (NRES > 1) ? $clog2(NRES) : 1;

  typedef struct packed {
    logic [NRES-1:0] busy;
    logic [NRES-1:0][15:0] owner;
  } tcbd_arb_st_t;

  tcbd_arb_st_t st;
  tcbd_arb_st_t next_st;
  logic [SW:0] map;
  logic mine;

  // slot 0 is the class resource, slots above map the control-set range
  function automatic logic [SW:0] sel_slot(input logic [7:0] sel);
    logic [SW:0] r;
    int s;
    r = '0;
    s = int'(sel) - 15;
    if (sel == `TCBD_RES_CLASS) begin
      r = {1'b1, SW'(0)};
    end else if (sel >= `TCBD_RES_CSET_LO && sel <= `TCBD_RES_CSET_HI &&
                 s < NRES) begin
      r = {1'b1, SW'(s)};
    end
    return r;
  endfunction

  assign map = sel_slot(i_sel);
  assign mine = st.busy[map[SW-1:0]] && st.owner[map[SW-1:0]] == i_lcn;
  assign o_busy = st.busy;

  // single owner per slot; reserved selectors are refused
  always_comb begin
    next_st = st;
    o_ok = 1'b0;
    o_bad = 1'b0;
    case (i_op)
      ROP_ACQ: begin
        if (!map[SW]) begin
          o_bad = 1'b1;
        end else if (!st.busy[map[SW-1:0]] || mine) begin
          o_ok = 1'b1;
          next_st.busy[map[SW-1:0]] = 1'b1;
          next_st.owner[map[SW-1:0]] = i_lcn;
        end
      end
      ROP_REL, ROP_ABD: begin
        if (map[SW] && mine) begin
          o_ok = 1'b1;
          next_st.busy[map[SW-1:0]] = 1'b0;
        end else begin
          o_bad = 1'b1;
        end
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  a_one_owner: assert property (@(posedge i_clk_sys)
    disable iff (!i_rst_b)
    (i_op == ROP_ACQ && st.busy[map[SW-1:0]] && !mine) |-> !o_ok)
    else $error("resource granted to a second channel");
  a_release_frees: assert property (@(posedge i_clk_sys)
    disable iff (!i_rst_b)
    (i_op == ROP_REL && o_ok) |=> !st.busy[$past(map[SW-1:0])])
    else $error("released resource still busy");

endmodule

`default_nettype wire

// File: tb/tcbd_init_model.sv
// initiator-side data mover model for the command block decoder
// assumes the decoder holds its movement request until done is seen
`timescale 1ns/1ps
`default_nettype none

module tcbd_init_model (
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic i_xfer_valid,
  input wire logic [3:0] i_dly,
  output logic o_xfer_done
);
  logic [3:0] cnt;

  // done after i_dly waiting cycles; one pulse per request, so a slow
  // mover is shown as well as a prompt one
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt <= 4'h0;
      o_xfer_done <= 1'b0;
    end else begin
      o_xfer_done <= 1'b0;
      if (i_xfer_valid && !o_xfer_done) begin
        if (cnt == i_dly) begin
          o_xfer_done <= 1'b1;
          cnt <= 4'h0;
        end else begin
          cnt <= cnt + 4'h1;
        end
      end
    end
  end
endmodule

`default_nettype wire

// File: tb/transport_command_block_decoder_tb.sv
// testbench for the command block decoder: blocks, announcements, regs
// assumes tcbd_pkg compiled first and the data mover model alongside
`timescale 1ns/1ps
`default_nettype none

module transport_command_block_decoder_tb
  import tcbd_pkg::*;
;
  logic clk, rst_b, cmd_v, ann_v, wr, rd, done, xfer_v, cpl_v, fwd_v;
  logic disc_v, cmd_rdy, ann_rdy, seen_x, seen_f, seen_d;
  logic [3:0] addr, dly;
  logic [31:0] wdata, rdata;
  tcbd_cmd_t cmd, fwd;
  tcbd_ann_t ann, disc, dd;
  tcbd_xfer_t xfer, xf;
  tcbd_cpl_t cpl;
  int error_cnt, checked;
  logic [7:0] rsv [10] = '{8'h00, 8'h04, 8'h07, 8'h0C, 8'h0F, 8'h10,
                           8'h6F, 8'h74, 8'h7F, 8'hFF};
  logic [7:0] fwc [4] = '{8'h0B, 8'h70, 8'h71, 8'h73};

  tcbd_decoder dut (.i_clk_sys(clk), .i_rst_b(rst_b), .i_cmd_valid(cmd_v),
    .i_cmd(cmd), .o_cmd_ready(cmd_rdy), .i_ann_valid(ann_v), .i_ann(ann),
    .o_ann_ready(ann_rdy), .o_xfer_valid(xfer_v), .o_xfer(xfer),
    .i_xfer_done(done), .o_cpl_valid(cpl_v), .o_cpl(cpl),
    .o_fwd_valid(fwd_v), .o_fwd(fwd), .o_discard_valid(disc_v),
    .o_discard(disc), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata));

  tcbd_init_model mover (.i_clk_sys(clk), .i_rst_b(rst_b),
    .i_xfer_valid(xfer_v), .i_dly(dly), .o_xfer_done(done));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic chk(input logic [79:0] got, input logic [79:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic reg_rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(rdata, e);
  endtask

  function automatic tcbd_cmd_t mk(input logic [15:0] lcn, input logic imm,
      input logic [7:0] fn, input logic [15:0] seq, input logic [7:0] sel,
      input logic [1:0] wa);
    mk = '0;
    mk.lcn = lcn;
    mk.imm = imm;
    mk.dir = imm;
    mk.fn = fn;
    mk.ptp = 1'b1;
    mk.page = 4'h3;
    mk.size = 16'h0028;
    mk.desc = 32'h0000_1000;
    mk.seq = seq;
    mk.sel = sel;
    {mk.wait_b, mk.accept} = wa;
  endfunction

  // offers one block, then watches side outputs until its completion
  task automatic blk(input tcbd_cmd_t c, input logic [3:0] code);
    int n;
    n = 0;
    seen_x = 1'b0;
    seen_f = 1'b0;
    seen_d = 1'b0;
    @(posedge clk);
    cmd_v <= 1'b1;
    cmd <= c;
    // look at ready between edges: the edge after a high ready takes it
    do begin
      @(negedge clk);
      n++;
      if (n > 50) begin
        error_cnt++;
        finish_test();
      end
    end while (cmd_rdy !== 1'b1);
    @(posedge clk);
    cmd_v <= 1'b0;
    n = 0;
    do begin
      @(negedge clk);
      n++;
      if (n > 50) begin
        error_cnt++;
        finish_test();
      end
      if (xfer_v === 1'b1) begin
        seen_x = 1'b1;
        xf = xfer;
      end
      if (fwd_v === 1'b1) seen_f = 1'b1;
      if (disc_v === 1'b1) begin
        seen_d = 1'b1;
        dd = disc;
      end
    end while (cpl_v !== 1'b1);
    chk(cpl, {c.lcn, c.imm, c.fn, code});
  endtask

  task automatic ann_put(input tcbd_ann_t a);
    @(posedge clk);
    ann_v <= 1'b1;
    ann <= a;
    @(negedge clk);
    chk(ann_rdy, 1'b1);
    @(posedge clk);
    ann_v <= 1'b0;
  endtask

  initial begin
    {rst_b, cmd_v, ann_v, wr, rd} = 5'h00;
    {addr, dly, wdata} = 40'h00_0000_0000;
    cmd = '0;
    ann = '0;
    error_cnt = 0;
    checked = 0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    reg_rd(4'h0, 32'h0000_0001);
    reg_rd(4'hC, 32'h0000_0000);
    // queued then immediate agent, prompt then slow mover
    for (int i = 0; i < 2; i++) begin
      dly <= 4'(3 * i);
      blk(mk(16'h0003, i[0], 8'h01, 16'h0000, 8'h00, 2'b00), 4'h0);
      chk(seen_x, 1'b1);
      chk(xf, {16'h0003, {2{i[0]}}, 5'h13, 48'h0028_0000_1000});
    end
    foreach (rsv[k]) begin
      blk(mk(16'h0002, 1'b0, rsv[k], 16'h0000, 8'h00, 2'b00), 4'h2);
      chk({seen_x, seen_f}, 2'b00);
    end
    foreach (fwc[k]) begin
      blk(mk(16'h0002, 1'b0, fwc[k], 16'h0000, 8'h00, 2'b00), 4'h0);
      chk(seen_f, 1'b1);
    end
    // control-set codes only pass once the set is enabled
    reg_wr(4'h0, 32'h0000_0003);
    blk(mk(16'h0002, 1'b0, 8'h10, 16'h0000, 8'h00, 2'b00), 4'h0);
    chk(seen_f, 1'b1);
    reg_wr(4'h0, 32'h0000_0001);
    // partial requested read, then cancel of the remainder
    ann_put('{16'h0005, 16'h0007, 16'h0064, 1'b1});
    blk(mk(16'h0005, 1'b1, 8'h02, 16'h0007, 8'h00, 2'b00), 4'h0);
    chk(xf.size, 16'h0028);
    chk({xf.agent, xf.dir}, 2'b11);
    blk(mk(16'h0005, 1'b1, 8'h02, 16'h0008, 8'h00, 2'b00), 4'h3);
    blk(mk(16'h0005, 1'b1, 8'h03, 16'h0007, 8'h00, 2'b00), 4'h0);
    chk({seen_d, dd}, {1'b1, 48'h0005_0007_003C, 1'b1});
    blk(mk(16'h0005, 1'b1, 8'h03, 16'h0007, 8'h00, 2'b00), 4'h3);
    ann_put('{16'h0006, 16'h0009, 16'h0004, 1'b0});
    blk(mk(16'h0006, 1'b1, 8'h03, 16'h0009, 8'h00, 2'b00), 4'h0);
    chk(seen_d, 1'b0);
    // resource contention between channels 1 and 2
    blk(mk(16'h0001, 1'b0, 8'h08, 16'h0000, 8'h00, 2'b00), 4'h0);
    blk(mk(16'h0002, 1'b0, 8'h08, 16'h0000, 8'h00, 2'b00), 4'h1);
    blk(mk(16'h0002, 1'b0, 8'h08, 16'h0000, 8'h01, 2'b00), 4'h4);
    blk(mk(16'h0001, 1'b0, 8'h0A, 16'h0000, 8'h00, 2'b00), 4'h0);
    blk(mk(16'h0002, 1'b0, 8'h08, 16'h0000, 8'h00, 2'b00), 4'h1);
    blk(mk(16'h0002, 1'b0, 8'h09, 16'h0000, 8'h00, 2'b00), 4'h4);
    blk(mk(16'h0001, 1'b0, 8'h0A, 16'h0000, 8'h00, 2'b01), 4'h0);
    blk(mk(16'h0002, 1'b0, 8'h08, 16'h0000, 8'h00, 2'b10), 4'h0);
    blk(mk(16'h0001, 1'b0, 8'h08, 16'h0000, 8'h10, 2'b10), 4'h0);
    blk(mk(16'h0002, 1'b0, 8'h09, 16'h0000, 8'h00, 2'b00), 4'h0);
    // 16 good and 16 failed completions; only the 0x10 slot stays owned
    reg_rd(4'h8, 32'h0010_0010);
    reg_rd(4'h4, 32'h0002_0000);
    reg_wr(4'h8, 32'h0000_0000);
    reg_rd(4'h8, 32'h0000_0000);
    finish_test();
  end
endmodule

`default_nettype wire
